// ===== design/input_receiver_feedback_config.sv
// Purpose: input loop receiver and feedback configuration registers
// Assumes: serial control port delivers one-cycle read/write strobes on clk_sys
// Notes:   controls are registered and move only on a write or reset
//
// Function
// (RULE1) Input register bit 7 enables the reference-test receiver; reset clear.
// (RULE2) Bit 6 sets secondary receiver differential; clear is single-ended using pin bit.
// (RULE3) Bit 5 sets primary receiver differential; clear is single-ended using pin bit.
// (RULE4) Bits 4 and 3 enable secondary and primary receivers, only when bit 2 set.
// (RULE5) Bit 2 clear keeps both reference receivers on regardless of enable bits.
// (RULE6) Bit 1 picks negative oscillator pin, only in single-ended mode.
// (RULE7) Bit 0 sets oscillator receiver differential; clear is single-ended.
// (RULE8) Feedback register bits 7 and 6 bypass reference-test and feedback dividers.
// (RULE9) Bit 5 picks internal zero delay when bit 4 clear, else external receiver.
// (RULE10) Bit 4 picks local oscillator feedback; clear uses zero delay feedback.
// (RULE11) Bit 2 sets zero-delay receiver differential; clear is single-ended.
// (RULE12) Bits 3, 1, 0 pick single-ended pins, only when not differential.
// (RULE13) Registers read back last write; controls change only on write or reset.
`include "input_receiver_feedback_config_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module input_receiver_feedback_config
	import input_receiver_feedback_config_pkg::*;
(
	input  wire logic clk_sys,       // 50 MHz system clock
	input  wire logic reset_n,       // async active-low reset
	input  wire reg_req_t reg_req,   // register request from serial port
	output var  reg_data_t reg_rdata, // read data, registered
	output logic      reg_rvalid,    // read data valid pulse
	output var  rx_ctrl_t rx_ctrl    // decoded receiver controls
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_n_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q   <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q   <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic addr_hit(input reg_addr_t addr, input reg_addr_t ofs);
		addr_hit = (addr == ofs);
	endfunction

	logic wr_rx;
	logic wr_fb;
	logic rd_rx;
	logic rd_fb;

	always_comb begin
		wr_rx = reg_req.wr & addr_hit(reg_req.addr, `IRF_INPUT_RX_CTRL_OFS);
		wr_fb = reg_req.wr & addr_hit(reg_req.addr, `IRF_FB_SE_CTRL_OFS);
		rd_rx = reg_req.rd & addr_hit(reg_req.addr, `IRF_INPUT_RX_CTRL_OFS);
		rd_fb = reg_req.rd & addr_hit(reg_req.addr, `IRF_FB_SE_CTRL_OFS);
	end

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	reg_data_t rx_reg_q;
	reg_data_t rx_reg_d;
	reg_data_t fb_reg_q;
	reg_data_t fb_reg_d;

	always_comb begin
		rx_reg_d = rx_reg_q;
		fb_reg_d = fb_reg_q;
		if (wr_rx) begin
			rx_reg_d = reg_req.wdata; // RULE13
		end
		if (wr_fb) begin
			fb_reg_d = reg_req.wdata; // RULE13
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			rx_reg_q <= `IRF_INPUT_RX_CTRL_RST;
			fb_reg_q <= `IRF_FB_SE_CTRL_RST;
		end else begin
			rx_reg_q <= rx_reg_d;
			fb_reg_q <= fb_reg_d;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	reg_data_t rdata_d;
	logic      rvalid_d;
	logic      rvalid_q;

	always_comb begin
		rvalid_d = reg_req.rd;
		rdata_d  = reg_rdata;
		if (reg_req.rd) begin
			// unmapped addresses read as zero
			rdata_d = `IRF_RDATA_RST;
			if (rd_rx) begin
				rdata_d = rx_reg_q; // RULE13
			end
			if (rd_fb) begin
				rdata_d = fb_reg_q; // RULE13
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			reg_rdata <= `IRF_RDATA_RST;
			rvalid_q  <= 1'b0;
		end else begin
			reg_rdata <= rdata_d;
			rvalid_q  <= rvalid_d;
		end
	end

	assign reg_rvalid = rvalid_q;

	// ------------------------------------------------------------
	// field unpack of the next register values
	// ------------------------------------------------------------
	logic ref_test_en_b;
	logic sec_diff_b;
	logic pri_diff_b;
	logic sec_en_b;
	logic pri_en_b;
	logic pd_ctrl_b;
	logic osc_neg_b;
	logic osc_diff_b;
	logic ref_test_byp_b;
	logic fb_byp_b;
	logic zd_int_b;
	logic local_fb_b;
	logic zd_sel_b;
	logic zd_diff_b;
	logic sec_sel_b;
	logic pri_sel_b;

	always_comb begin
		ref_test_en_b  = rx_reg_d[`IRF_RX_REF_TEST_EN];
		sec_diff_b     = rx_reg_d[`IRF_RX_SEC_DIFF];
		pri_diff_b     = rx_reg_d[`IRF_RX_PRI_DIFF];
		sec_en_b       = rx_reg_d[`IRF_RX_SEC_EN];
		pri_en_b       = rx_reg_d[`IRF_RX_PRI_EN];
		pd_ctrl_b      = rx_reg_d[`IRF_RX_PD_CTRL_EN];
		osc_neg_b      = rx_reg_d[`IRF_RX_OSC_NEG_SEL];
		osc_diff_b     = rx_reg_d[`IRF_RX_OSC_DIFF];
		ref_test_byp_b = fb_reg_d[`IRF_FB_REF_TEST_BYP];
		fb_byp_b       = fb_reg_d[`IRF_FB_FB_DIV_BYP];
		zd_int_b       = fb_reg_d[`IRF_FB_ZD_INTERNAL];
		local_fb_b     = fb_reg_d[`IRF_FB_LOCAL_FB];
		zd_sel_b       = fb_reg_d[`IRF_FB_ZD_SE_SEL];
		zd_diff_b      = fb_reg_d[`IRF_FB_ZD_DIFF];
		sec_sel_b      = fb_reg_d[`IRF_FB_SEC_SE_SEL];
		pri_sel_b      = fb_reg_d[`IRF_FB_PRI_SE_SEL];
	end

	// ------------------------------------------------------------
	// control decode
	// ------------------------------------------------------------
	rx_ctrl_t ctrl_d;

	always_comb begin
		ctrl_d = rx_ctrl;
		// reference-test receiver
		ctrl_d.ref_test_rx_en = ref_test_en_b; // RULE1
		// primary reference receiver
		ctrl_d.pri_rx_diff = pri_diff_b; // RULE3
		// power-down handed to enable bits only while control is enabled
		ctrl_d.pri_rx_on = pd_ctrl_b ? pri_en_b : 1'b1; // RULE4 RULE5
		ctrl_d.pri_se_pin_sel = pri_sel_b & ~pri_diff_b; // RULE12
		// secondary reference receiver
		ctrl_d.sec_rx_diff = sec_diff_b; // RULE2
		ctrl_d.sec_rx_on = pd_ctrl_b ? sec_en_b : 1'b1; // RULE4 RULE5
		ctrl_d.sec_se_pin_sel = sec_sel_b & ~sec_diff_b; // RULE12
		// oscillator receiver: differential uses both pins
		ctrl_d.osc_rx_diff = osc_diff_b; // RULE7
		ctrl_d.osc_pos_pin_en = osc_diff_b | ~osc_neg_b; // RULE6
		ctrl_d.osc_neg_pin_en = osc_diff_b | osc_neg_b; // RULE6
		// divider bypass
		ctrl_d.ref_test_div_bypass = ref_test_byp_b; // RULE8
		ctrl_d.fb_div_bypass = fb_byp_b; // RULE8
		// feedback path: zero delay mode bit ignored under local feedback
		ctrl_d.local_fb_sel = local_fb_b; // RULE10
		ctrl_d.zd_internal = ~local_fb_b & zd_int_b; // RULE9
		ctrl_d.zd_rx_on = ~local_fb_b & ~zd_int_b; // RULE9
		// zero-delay receiver mode
		ctrl_d.zd_rx_diff = zd_diff_b; // RULE11
		ctrl_d.zd_se_pin_sel = zd_sel_b & ~zd_diff_b; // RULE12
	end

	// ------------------------------------------------------------
	// control output registers
	// ------------------------------------------------------------
	logic ctrl_load;

	assign ctrl_load = wr_rx | wr_fb;

	always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			// reset state matches both registers at zero:
			// reference receivers on, positive oscillator pin, external zero delay
			rx_ctrl.ref_test_rx_en      <= 1'b0;
			rx_ctrl.pri_rx_diff         <= 1'b0;
			rx_ctrl.pri_rx_on           <= 1'b1;
			rx_ctrl.pri_se_pin_sel      <= 1'b0;
			rx_ctrl.sec_rx_diff         <= 1'b0;
			rx_ctrl.sec_rx_on           <= 1'b1;
			rx_ctrl.sec_se_pin_sel      <= 1'b0;
			rx_ctrl.osc_rx_diff         <= 1'b0;
			rx_ctrl.osc_pos_pin_en      <= 1'b1;
			rx_ctrl.osc_neg_pin_en      <= 1'b0;
			rx_ctrl.ref_test_div_bypass <= 1'b0;
			rx_ctrl.fb_div_bypass       <= 1'b0;
			rx_ctrl.local_fb_sel        <= 1'b0;
			rx_ctrl.zd_internal         <= 1'b0;
			rx_ctrl.zd_rx_on            <= 1'b1;
			rx_ctrl.zd_rx_diff          <= 1'b0;
			rx_ctrl.zd_se_pin_sel       <= 1'b0;
		end else if (ctrl_load) begin
			rx_ctrl <= ctrl_d; // RULE13
		end
	end

endmodule

`default_nettype wire

// ===== shared/input_receiver_feedback_config_defs.svh
// Purpose: offsets, bit positions and reset values of the input loop receiver/feedback bank
// Assumes: 8-bit registers, 12-bit serial port register address
// Notes:   definitions only
`ifndef INPUT_RECEIVER_FEEDBACK_CONFIG_DEFS_SVH
`define INPUT_RECEIVER_FEEDBACK_CONFIG_DEFS_SVH

`define IRF_ADDR_W              12
`define IRF_DATA_W              8

// register offsets
`define IRF_INPUT_RX_CTRL_OFS   12'h01a
`define IRF_FB_SE_CTRL_OFS      12'h01b

// reset values
`define IRF_INPUT_RX_CTRL_RST   8'h00
`define IRF_FB_SE_CTRL_RST      8'h00
`define IRF_RDATA_RST           8'h00

// input receiver control bits
`define IRF_RX_REF_TEST_EN      7
`define IRF_RX_SEC_DIFF         6
`define IRF_RX_PRI_DIFF         5
`define IRF_RX_SEC_EN           4
`define IRF_RX_PRI_EN           3
`define IRF_RX_PD_CTRL_EN       2
`define IRF_RX_OSC_NEG_SEL      1
`define IRF_RX_OSC_DIFF         0

// feedback and single-ended control bits
`define IRF_FB_REF_TEST_BYP     7
`define IRF_FB_FB_DIV_BYP       6
`define IRF_FB_ZD_INTERNAL      5
`define IRF_FB_LOCAL_FB         4
`define IRF_FB_ZD_SE_SEL        3
`define IRF_FB_ZD_DIFF          2
`define IRF_FB_SEC_SE_SEL       1
`define IRF_FB_PRI_SE_SEL       0

`endif

// ===== shared/input_receiver_feedback_config_pkg.sv
// Purpose: types of the input loop receiver/feedback bank
// Assumes: constants live in the defs header
// Notes:   request and control bundles travel as packed structs
`include "input_receiver_feedback_config_defs.svh"
`default_nettype none

package input_receiver_feedback_config_pkg;

	typedef logic [`IRF_ADDR_W-1:0] reg_addr_t;
	typedef logic [`IRF_DATA_W-1:0] reg_data_t;

	// one register request from the serial control port
	typedef struct packed {
		reg_addr_t addr;
		logic      wr;
		logic      rd;
		reg_data_t wdata;
	} reg_req_t;

	// decoded receiver and feedback controls
	typedef struct packed {
		logic ref_test_rx_en;
		logic pri_rx_diff;
		logic pri_rx_on;
		logic pri_se_pin_sel;
		logic sec_rx_diff;
		logic sec_rx_on;
		logic sec_se_pin_sel;
		logic osc_rx_diff;
		logic osc_pos_pin_en;
		logic osc_neg_pin_en;
		logic ref_test_div_bypass;
		logic fb_div_bypass;
		logic local_fb_sel;
		logic zd_internal;
		logic zd_rx_on;
		logic zd_rx_diff;
		logic zd_se_pin_sel;
	} rx_ctrl_t;

endpackage

`default_nettype wire

// ===== sim/input_receiver_feedback_config_props.sv
// Purpose: port checks of the input loop receiver/feedback bank
// Assumes: one clock domain, reset_n low suspends all checks
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none

module input_receiver_feedback_config_props
	import input_receiver_feedback_config_pkg::*;
(
	input wire logic      clk_sys,    // system clock
	input wire logic      reset_n,    // async reset, active low
	input wire reg_req_t  reg_req,    // register request
	input wire reg_data_t reg_rdata,  // read data
	input wire logic      reg_rvalid, // read data valid
	input wire rx_ctrl_t  rx_ctrl     // decoded controls
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic      map_wr;
	reg_data_t wd_q;
	assign map_wr = reg_req.wr && (reg_req.addr == 12'h01a || reg_req.addr == 12'h01b);
	always_ff @(posedge clk_sys) begin
		wd_q <= reg_req.wdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence rx_wr_s;
		reg_req.wr && reg_req.addr == 12'h01a;
	endsequence
	sequence fb_wr_s;
		reg_req.wr && reg_req.addr == 12'h01b;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	rvalid_pulse_a: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read valid missing after read");
	rvalid_only_a: assert property (!reg_req.rd |=> !reg_rvalid)
		else $error("read valid without read");
	ctrl_hold_a: assert property (!map_wr |=> $stable(rx_ctrl))
		else $error("controls moved without write");
	rx_write_a: assert property (rx_wr_s |=> rx_ctrl.ref_test_rx_en == wd_q[7]
		&& rx_ctrl.pri_rx_on == (!wd_q[2] || wd_q[3]) && rx_ctrl.sec_rx_on == (!wd_q[2] || wd_q[4]))
		else $error("receiver controls differ from write");
	fb_write_a: assert property (fb_wr_s |=> rx_ctrl.ref_test_div_bypass == wd_q[7]
		&& rx_ctrl.fb_div_bypass == wd_q[6] && rx_ctrl.local_fb_sel == wd_q[4])
		else $error("feedback controls differ from write");
	osc_pins_a: assert property ((rx_ctrl.osc_pos_pin_en && rx_ctrl.osc_neg_pin_en)
		== rx_ctrl.osc_rx_diff && (rx_ctrl.osc_pos_pin_en || rx_ctrl.osc_neg_pin_en))
		else $error("oscillator pin enables wrong");
	zd_path_a: assert property (rx_ctrl.local_fb_sel ? !(rx_ctrl.zd_internal || rx_ctrl.zd_rx_on)
		: rx_ctrl.zd_internal != rx_ctrl.zd_rx_on)
		else $error("zero delay path wrong");
	se_pin_a: assert property (!(rx_ctrl.pri_rx_diff && rx_ctrl.pri_se_pin_sel)
		&& !(rx_ctrl.sec_rx_diff && rx_ctrl.sec_se_pin_sel) && !(rx_ctrl.zd_rx_diff && rx_ctrl.zd_se_pin_sel))
		else $error("pin select active in differential mode");
endmodule

bind input_receiver_feedback_config input_receiver_feedback_config_props props_u (
	.clk_sys, .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .rx_ctrl);

`default_nettype wire

// ===== sim/testbench.sv
// Purpose: self-checking bench of the receiver/feedback bank
// Assumes: strobe port driven on falling clock edges
// Notes:   expected controls derived bit by bit from register values
`timescale 1ns/1ps
`default_nettype none

module testbench
	import input_receiver_feedback_config_pkg::*;
;
	logic      clk_sys = 1'b0;
	logic      reset_n = 1'b0;
	reg_req_t  reg_req = '0;
	reg_data_t reg_rdata;
	logic      reg_rvalid;
	rx_ctrl_t  rx_ctrl;
	int        failures = 0;
	int        n_compared = 0;
	logic [7:0] tab_a [6] = '{8'h00, 8'hff, 8'h1c, 8'h14, 8'ha6, 8'h4b};
	logic [7:0] tab_b [6] = '{8'h00, 8'hff, 8'h20, 8'h0b, 8'hd0, 8'h04};

	input_receiver_feedback_config dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_ctrl(rx_ctrl));

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic rx_ctrl_t exp_ctrl(logic [7:0] a, logic [7:0] b);
		return '{a[7], a[5], !a[2] || a[3], b[0] & ~a[5], a[6], !a[2] || a[4], b[1] & ~a[6], a[0],
			a[0] | ~a[1], a[0] | a[1], b[7], b[6], b[4], ~b[4] & b[5], ~b[4] & ~b[5], b[2], b[3] & ~b[2]};
	endfunction
	task automatic chk(string what, logic [16:0] exp, logic [16:0] act);
		n_compared++;
		if (act !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(negedge clk_sys);
		reg_req = '{a, 1'b1, 1'b0, d};
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] exp);
		@(negedge clk_sys);
		reg_req = '{a, 1'b0, 1'b1, 8'h00};
		@(negedge clk_sys);
		reg_req = '0;
		chk("rvalid", 17'h1, reg_rvalid);
		chk("rdata", exp, reg_rdata);
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic end_of_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		do_reset();
		chk("reset ctrl", exp_ctrl(8'h00, 8'h00), rx_ctrl);
		rd(12'h01a, 8'h00);
		rd(12'h01b, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(12'h01a, tab_a[i]);
			wr(12'h01b, tab_b[i]);
			@(negedge clk_sys);
			reg_req = '0;
			chk("ctrl", exp_ctrl(tab_a[i], tab_b[i]), rx_ctrl);
			rd(12'h01a, tab_a[i]);
			rd(12'h01b, tab_b[i]);
		end
		wr(12'h01c, 8'h00);
		@(negedge clk_sys);
		reg_req = '0;
		chk("unmapped write", exp_ctrl(tab_a[5], tab_b[5]), rx_ctrl);
		rd(12'h01c, 8'h00);
		do_reset();
		chk("second reset", exp_ctrl(8'h00, 8'h00), rx_ctrl);
		rd(12'h01a, 8'h00);
		end_of_test();
	end
endmodule

`default_nettype wire
